// File: verilog/sbsp_consts.vh
`ifndef SBSP_CONSTS_VH
`define SBSP_CONSTS_VH
// Byte lanes on the data bus
`define SBSP_LANES 8
// Bits per lane, the top bit being the parity position
`define SBSP_LANE_W 9
// Full data bus width
`define SBSP_DATA_W 72
// Word address width, 256K words of 72 bits
`define SBSP_ADDR_W 18
// Word count of the storage array
`define SBSP_DEPTH 262144
// Burst counter width, four beats
`define SBSP_BURST_W 2
// Burst counter start and step
`define SBSP_BURST_ZERO 2'h0
`define SBSP_BURST_ONE 2'h1
// Test port instruction register
`define SBSP_IR_W 3
`define SBSP_IR_BYPASS 3'h7
`define SBSP_IR_IDCODE 3'h1
`define SBSP_IR_CAPTURE 3'h1
// Test port identity register width
`define SBSP_ID_W 32
// Identity code, arbitrary neutral value with the mandatory low bit set
`define SBSP_ID_CODE 32'h00000001
`endif

// File: verilog/sbsp_array.v
`timescale 1ns/1ns
`default_nettype none
`include "sbsp_consts.vh"
module sbsp_array (
  input  wire                      i_clk,
  input  wire                      i_reset,
  input  wire                      i_en,
  input  wire                      i_rd,
  input  wire [`SBSP_ADDR_W-1:0]   i_rd_addr,
  output reg  [`SBSP_DATA_W-1:0]   o_rd_data,
  input  wire                      i_wr,
  input  wire [`SBSP_ADDR_W-1:0]   i_wr_addr,
  input  wire [`SBSP_DATA_W-1:0]   i_wr_data,
  input  wire [`SBSP_LANES-1:0]    i_wr_lanes
);
  // Storage words, full bus width
  reg [`SBSP_DATA_W-1:0] mem_r [0:`SBSP_DEPTH-1];
  integer k;

  // Registered read, lane masked write; read sees old data on a collision
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_rd_data <= {`SBSP_DATA_W{1'b0}};
    end else if (i_en) begin
      if (i_rd) begin
        o_rd_data <= mem_r[i_rd_addr];
      end
    end
    if (i_en && i_wr) begin
      for (k = 0; k < `SBSP_LANES; k = k + 1) begin
        // Only enabled lanes change
        if (i_wr_lanes[k]) begin
          mem_r[i_wr_addr][k*`SBSP_LANE_W +: `SBSP_LANE_W] <=
            i_wr_data[k*`SBSP_LANE_W +: `SBSP_LANE_W];
        end
      end
    end
  end
endmodule // sbsp_array
`default_nettype wire

// File: verilog/sbsp_tap.v
`timescale 1ns/1ns
`default_nettype none
`include "sbsp_consts.vh"
module sbsp_tap (
  input  wire i_clk,
  input  wire i_reset,
  input  wire i_tck,
  input  wire i_tms,
  input  wire i_tdi,
  output reg  o_tdo,
  output reg  o_tdo_oe
);
  localparam TLR = 4'h0, RTI = 4'h1, SDR = 4'h2, CDR = 4'h3;
  localparam SHD = 4'h4, E1D = 4'h5, PDR = 4'h6, E2D = 4'h7;
  localparam UDR = 4'h8, SIR = 4'h9, CIR = 4'hA, SHI = 4'hB;
  localparam E1I = 4'hC, PIR = 4'hD, E2I = 4'hE, UIR = 4'hF;

  reg  [3:0]             st_r;    // Controller state
  reg  [3:0]             st_nxt;  // Next state on a test clock rise
  reg                    tck_r;   // Test clock, last sample
  reg  [`SBSP_IR_W-1:0]  ir_r;    // Active instruction
  reg  [`SBSP_IR_W-1:0]  irs_r;   // Instruction shift stage
  reg  [`SBSP_ID_W-1:0]  dr_r;    // Identity or bypass shift stage
  wire rise = i_tck & ~tck_r;     // Test clock edges seen on i_clk
  wire fall = ~i_tck & tck_r;
  wire byp  = (ir_r == `SBSP_IR_BYPASS);

  // Standard sixteen state walk on TMS
  always @* begin
    case (st_r)
      TLR: st_nxt = i_tms ? TLR : RTI;
      RTI: st_nxt = i_tms ? SDR : RTI;
      SDR: st_nxt = i_tms ? SIR : CDR;
      CDR: st_nxt = i_tms ? E1D : SHD;
      SHD: st_nxt = i_tms ? E1D : SHD;
      E1D: st_nxt = i_tms ? UDR : PDR;
      PDR: st_nxt = i_tms ? E2D : PDR;
      E2D: st_nxt = i_tms ? UDR : SHD;
      UDR: st_nxt = i_tms ? SDR : RTI;
      SIR: st_nxt = i_tms ? TLR : CIR;
      CIR: st_nxt = i_tms ? E1I : SHI;
      SHI: st_nxt = i_tms ? E1I : SHI;
      E1I: st_nxt = i_tms ? UIR : PIR;
      PIR: st_nxt = i_tms ? E2I : PIR;
      E2I: st_nxt = i_tms ? UIR : SHI;
      default: st_nxt = i_tms ? SDR : RTI;
    endcase
  end

  // Capture and shift on the rise, drive out on the fall
  always @(posedge i_clk) begin
    tck_r <= i_tck;
    if (i_reset) begin
      st_r     <= TLR;
      ir_r     <= `SBSP_IR_IDCODE;
      irs_r    <= `SBSP_IR_CAPTURE;
      dr_r     <= {`SBSP_ID_W{1'b0}};
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      if (rise) begin
        st_r <= st_nxt;
        if (st_r == TLR) begin
          ir_r <= `SBSP_IR_IDCODE;
        end
        if (st_r == CDR) begin
          dr_r <= byp ? {`SBSP_ID_W{1'b0}} : `SBSP_ID_CODE;
        end
        if (st_r == SHD) begin
          // Bypass is a one bit path
          if (byp) begin
            dr_r[0] <= i_tdi;
          end else begin
            dr_r <= {i_tdi, dr_r[`SBSP_ID_W-1:1]};
          end
        end
        if (st_r == CIR) begin
          irs_r <= `SBSP_IR_CAPTURE;
        end
        if (st_r == SHI) begin
          irs_r <= {i_tdi, irs_r[`SBSP_IR_W-1:1]};
        end
        if (st_r == UIR) begin
          ir_r <= irs_r;
        end
      end
      if (fall) begin
        o_tdo    <= (st_r == SHI) ? irs_r[0] : dr_r[0];
        o_tdo_oe <= (st_r == SHI) || (st_r == SHD);
      end
    end
  end
endmodule // sbsp_tap
`default_nettype wire

// File: verilog/sbsp_port.v
// How it works
// - Address, data, control taken on rising edge
// - Burst order pin picks linear or interleaved
// - Sleep and output enable act without clock
// - Output enable off drops drive at once
// - Writes start on edge, self timed internally
// - Pipelined read data waits one output register
// - Read and write may alternate back to back
// - Pipelined: double late write; flow: single
// - Writes masked per nine bit lane
// - Three chip selects must all be active
// - Static mode pin sets latency and lag
// - Sleep stops all new accesses
// - Boundary scan port on four test wires
// - Array holds 18 Mbit of full words
// - Clock gate low-active stalls all but the test port
// - Load cycle with all selects starts access
// - Write with no lane enabled does nothing
`timescale 1ns/1ns
`default_nettype none
`include "sbsp_consts.vh"
module sbsp_port (
  input  wire                      i_clk,
  input  wire                      i_reset,
  // Clock gate, active low
  input  wire                      i_clk_enable_n,
  // Word address
  input  wire [`SBSP_ADDR_W-1:0]   i_addr,
  // Write command, active low
  input  wire                      i_write_n,
  // Per lane write enables, active low
  input  wire [`SBSP_LANES-1:0]    i_lane_enable_n,
  // Chip selects
  input  wire                      i_chip_select_a_n,
  input  wire                      i_chip_select_b,
  input  wire                      i_chip_select_c_n,
  // High continues the burst, low loads
  input  wire                      i_advance_load,
  // Asynchronous controls
  input  wire                      i_output_enable_n,
  input  wire                      i_sleep_request,
  // Static straps
  input  wire                      i_flow_through_select_n,
  input  wire                      i_burst_order_select_n,
  // Data pins, split into in, out and enable
  input  wire [`SBSP_DATA_W-1:0]   i_data,
  output wire [`SBSP_DATA_W-1:0]   o_data,
  output wire                      o_data_oe,
  // Test port
  input  wire                      i_tck,
  input  wire                      i_tms,
  input  wire                      i_tdi,
  output wire                      o_tdo,
  output wire                      o_tdo_oe
);

  // Burst beat offset; only the two low address bits move
  function [`SBSP_BURST_W-1:0] sbsp_beat;
    input [`SBSP_BURST_W-1:0] base;
    input [`SBSP_BURST_W-1:0] cnt;
    input                     lin;
    begin
      // Linear wraps within four, interleaved flips bits
      if (lin) begin
        sbsp_beat = base + cnt;
      end else begin
        sbsp_beat = base ^ cnt;
      end
    end
  endfunction

  // Internal clock is passed only while the gate is low
  wire en = ~i_clk_enable_n;

  // Sleep blocks new commands without waiting for an edge
  wire go = en & ~i_sleep_request;

  // Device is picked only with every select active
  wire sel = ~i_chip_select_a_n & i_chip_select_b & ~i_chip_select_c_n;

  // Load cycle when advance is low
  wire load = ~i_advance_load;

  // Strap levels; the straps are expected to stay put
  wire lin = ~i_burst_order_select_n;
  wire ft  = ~i_flow_through_select_n;

  // Burst tracking
  reg                         bst_act_r; // A burst is open
  reg                         bst_wr_r;  // Open burst is a write
  reg  [`SBSP_ADDR_W-1:0]     bst_base_r; // Address of the load
  reg  [`SBSP_BURST_W-1:0]    bst_cnt_r; // Beats taken so far
  wire [`SBSP_BURST_W-1:0]    cnt_nxt;   // Next beat count

  // Command of this edge
  reg                         cmd_v;    // Access happens
  reg                         cmd_wr;   // Access is a write
  reg  [`SBSP_ADDR_W-1:0]     cmd_addr; // Word it hits
  wire                        issue;    // Accepted this edge

  // First stage, the command edge
  reg                         s1_v_r;
  reg                         s1_wr_r;
  reg  [`SBSP_ADDR_W-1:0]     s1_addr_r;
  reg  [`SBSP_LANES-1:0]      s1_lanes_r;

  // Second stage, used by pipelined writes only
  reg                         s2_v_r;
  reg                         s2_wr_r;
  reg  [`SBSP_ADDR_W-1:0]     s2_addr_r;
  reg  [`SBSP_LANES-1:0]      s2_lanes_r;

  // Read progress markers
  reg                         rd1_r; // Array data ready
  reg                         rd2_r; // Output register loaded

  // Output register of the pipelined read
  reg  [`SBSP_DATA_W-1:0]     out_r;

  // Array read data, a flip-flop inside the array
  wire [`SBSP_DATA_W-1:0]     rd_data;

  // Write port, selected by mode
  wire                        wr_en;
  wire [`SBSP_ADDR_W-1:0]     wr_addr;
  wire [`SBSP_LANES-1:0]      wr_lanes;

  assign cnt_nxt = bst_cnt_r + `SBSP_BURST_ONE;

  // Decode the command seen at this edge
  always @* begin
    if (load) begin
      // New address loaded, kind taken from the write pin
      cmd_v    = sel;
      cmd_wr   = ~i_write_n;
      cmd_addr = i_addr;
    end else begin
      // Continue the open burst with its own kind
      cmd_v    = bst_act_r;
      cmd_wr   = bst_wr_r;
      cmd_addr = {bst_base_r[`SBSP_ADDR_W-1:`SBSP_BURST_W],
                  sbsp_beat(bst_base_r[`SBSP_BURST_W-1:0], cnt_nxt, lin)};
    end
  end

  // Accepted only on an enabled, awake edge
  assign issue = go & cmd_v;

  // Burst state; a deselect on a load closes the burst
  always @(posedge i_clk) begin
    if (i_reset) begin
      bst_act_r  <= 1'b0;
      bst_wr_r   <= 1'b0;
      bst_base_r <= {`SBSP_ADDR_W{1'b0}};
      bst_cnt_r  <= `SBSP_BURST_ZERO;
    end else if (go) begin
      if (load) begin
        bst_act_r  <= sel;
        bst_wr_r   <= ~i_write_n;
        bst_base_r <= i_addr;
        bst_cnt_r  <= `SBSP_BURST_ZERO;
      end else if (bst_act_r) begin
        // Counter wraps after four beats
        bst_cnt_r  <= cnt_nxt;
      end
    end
  end

  // Command pipeline; frozen while the clock gate is off
  always @(posedge i_clk) begin
    if (i_reset) begin
      s1_v_r     <= 1'b0;
      s1_wr_r    <= 1'b0;
      s1_addr_r  <= {`SBSP_ADDR_W{1'b0}};
      s1_lanes_r <= {`SBSP_LANES{1'b0}};
      s2_v_r     <= 1'b0;
      s2_wr_r    <= 1'b0;
      s2_addr_r  <= {`SBSP_ADDR_W{1'b0}};
      s2_lanes_r <= {`SBSP_LANES{1'b0}};
    end else if (en) begin
      // Lane enables ride with the command
      s1_v_r     <= issue;
      s1_wr_r    <= cmd_wr;
      s1_addr_r  <= cmd_addr;
      s1_lanes_r <= ~i_lane_enable_n;
      // No bubble needed between reads and writes
      s2_v_r     <= s1_v_r;
      s2_wr_r    <= s1_wr_r;
      s2_addr_r  <= s1_addr_r;
      s2_lanes_r <= s1_lanes_r;
    end
  end

  // Read markers and the output register
  always @(posedge i_clk) begin
    if (i_reset) begin
      rd1_r <= 1'b0;
      rd2_r <= 1'b0;
      out_r <= {`SBSP_DATA_W{1'b0}};
    end else if (en) begin
      rd1_r <= issue & ~cmd_wr;
      // Data held one more edge before reaching the pins
      rd2_r <= rd1_r;
      out_r <= rd_data;
    end
  end

  // Data is taken one edge after the command in flow mode,
  // two edges after in pipelined mode, so both latencies match
  assign wr_en    = ft ? (s1_v_r & s1_wr_r) : (s2_v_r & s2_wr_r);
  assign wr_addr  = ft ? s1_addr_r  : s2_addr_r;
  assign wr_lanes = ft ? s1_lanes_r : s2_lanes_r;

  // Storage, 256K words of 72 bits; the write itself needs no pulse
  sbsp_array u_array (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_en       (en),
    .i_rd       (issue & ~cmd_wr),
    .i_rd_addr  (cmd_addr),
    .o_rd_data  (rd_data),
    .i_wr       (wr_en),
    .i_wr_addr  (wr_addr),
    .i_wr_data  (i_data),
    .i_wr_lanes (wr_lanes)
  );

  // Flow mode shows the array flop, pipelined the output register
  assign o_data = ft ? rd_data : out_r;

  // Enable is gated without any clock; sleep also drops it
  assign o_data_oe = (ft ? rd1_r : rd2_r) & ~i_output_enable_n & ~i_sleep_request;

  // Test access port, run from the main clock on test clock edges
  sbsp_tap u_tap (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_tck    (i_tck),
    .i_tms    (i_tms),
    .i_tdi    (i_tdi),
    .o_tdo    (o_tdo),
    .o_tdo_oe (o_tdo_oe)
  );

endmodule // sbsp_port
`default_nettype wire

// File: tb/sbsp_port_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbsp_consts.vh"
module sbsp_port_sva (
  input wire logic                    i_clk,
  input wire logic                    i_reset,
  input wire logic                    i_clk_enable_n,
  input wire logic                    i_write_n,
  input wire logic                    i_chip_select_a_n,
  input wire logic                    i_chip_select_b,
  input wire logic                    i_chip_select_c_n,
  input wire logic                    i_advance_load,
  input wire logic                    i_output_enable_n,
  input wire logic                    i_sleep_request,
  input wire logic                    i_flow_through_select_n,
  input wire logic [`SBSP_DATA_W-1:0] o_data,
  input wire logic                    o_data_oe,
  input wire logic                    o_tdo_oe
);
  // All three selects active
  wire sel  = !i_chip_select_a_n && i_chip_select_b && !i_chip_select_c_n;
  // Async pins letting the drivers on
  wire pins = !i_output_enable_n && !i_sleep_request;
  // High strap means pipelined
  wire pipe = i_flow_through_select_n;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Counted load cycles of each kind
  sequence s_rd; !i_clk_enable_n && !i_sleep_request && !i_advance_load && sel && i_write_n;
  endsequence
  sequence s_wr; !i_clk_enable_n && !i_sleep_request && !i_advance_load && sel && !i_write_n;
  endsequence
  // Two counted edges in a row
  sequence s_two; !i_clk_enable_n [*2]; endsequence
  reset_quiet_a: assert property ($fell(i_reset) |-> !o_data_oe && o_data == 72'h0 && !o_tdo_oe)
    else $error("outputs not quiet after reset");
  pipe_read_a: assert property (pipe ##0 s_rd ##1 !i_clk_enable_n ##1 pins |-> o_data_oe)
    else $error("pipelined read not driven two edges later");
  flow_read_a: assert property (!pipe ##0 s_rd ##1 pins |-> o_data_oe)
    else $error("flow read not driven after command edge");
  pipe_write_a: assert property (pipe ##0 s_wr ##1 !i_clk_enable_n |=> !o_data_oe)
    else $error("pipelined write drove the data pins");
  flow_write_a: assert property (!pipe ##0 s_wr |=> !o_data_oe)
    else $error("flow write drove the data pins");
  oe_async_a: assert property (i_output_enable_n |-> !o_data_oe)
    else $error("drive enable ignored");
  sleep_quiet_a: assert property (i_sleep_request |-> !o_data_oe)
    else $error("drivers on during sleep");
  stall_hold_a: assert property (i_clk_enable_n |=> $stable(o_data))
    else $error("data moved on a gated edge");
endmodule // sbsp_port_sva
`default_nettype wire

// File: tb/sbsp_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module sbsp_ctrl_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_clk_enable_n,
  input  wire logic        i_flow_through_select_n,
  input  wire logic        i_wr_taken,
  input  wire logic [71:0] i_wr_data,
  input  wire logic [71:0] i_dev_data,
  input  wire logic        i_dev_oe,
  output wire logic [71:0] o_bus
);
  logic [71:0] d1_r, d2_r, last_r; // Data lag stages, last bus level
  logic        v1_r, v2_r;         // Stage holds write data
  // Pipelined data two edges late, flow one edge late
  wire         drv = i_flow_through_select_n ? v2_r : v1_r;
  wire  [71:0] dsel = i_flow_through_select_n ? d2_r : d1_r;
  // Write data wins: real bus splits the cycle, this model does not
  assign o_bus = drv ? dsel : i_dev_oe ? i_dev_data : ~last_r;
  // Released bus toggles so a stale value never looks valid
  always @(posedge i_clk) begin
    last_r <= o_bus;
    if (i_reset) begin
      v1_r <= 1'b0;
      v2_r <= 1'b0;
    end else if (!i_clk_enable_n) begin
      v1_r <= i_wr_taken;
      d1_r <= i_wr_data;
      v2_r <= v1_r;
      d2_r <= d1_r;
    end
  end
endmodule // sbsp_ctrl_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbsp_consts.vh"
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
  logic i_clk = 0, i_reset = 1, ce_n = 0, wr_n = 1, a_n = 1, b = 0, c_n = 1; // Bus controls
  logic advance_load = 0, oe_n = 0, slp = 0, ft_n = 1, lbo_n = 1;                    // Burst advance, async pins, straps
  logic [17:0] addr = 18'h0;                                                // Word address
  logic [7:0]  ln_n = 8'hFF;                                                // Lane enables
  logic        wt = 0, rv = 0;                                              // Taken write, read
  logic [71:0] wd = 72'h0, re = 72'h0;                                      // Write, expected data
  logic        r1 = 0, r2 = 0;                                              // Read stages
  logic [71:0] e1, e2;                                                      // Expected per stage
  logic        tck = 0, tms = 0;                                            // Test port drive
  wire         tdo, tdoe;                                                   // Test port out
  logic [31:0] idv;                                                         // Shifted identity
  logic [71:0] mem [int];                                                   // Reference store
  wire  [71:0] bus, dout;
  wire         doe;
  int          error_cnt = 0, n_checks = 0, cyc = 0;
  always #50 i_clk = ~i_clk;
  sbsp_port u_sbsp_port (.i_clk(i_clk), .i_reset(i_reset), .i_clk_enable_n(ce_n),
    .i_addr(addr), .i_write_n(wr_n), .i_lane_enable_n(ln_n), .i_chip_select_a_n(a_n),
    .i_chip_select_b(b), .i_chip_select_c_n(c_n), .i_advance_load(advance_load),
    .i_output_enable_n(oe_n), .i_sleep_request(slp), .i_flow_through_select_n(ft_n),
    .i_burst_order_select_n(lbo_n), .i_data(bus), .o_data(dout), .o_data_oe(doe),
    .i_tck(tck), .i_tms(tms), .i_tdi(1'b0), .o_tdo(tdo), .o_tdo_oe(tdoe));
  sbsp_ctrl_model u_sbsp_ctrl_model (.i_clk(i_clk), .i_reset(i_reset), .i_clk_enable_n(ce_n),
    .i_flow_through_select_n(ft_n), .i_wr_taken(wt), .i_wr_data(wd), .i_dev_data(dout),
    .i_dev_oe(doe), .o_bus(bus));
  // Distinct word per index
  function automatic logic [71:0] pat(input logic [8:0] k);
    pat = {8{k}} ^ 72'hA5A5A5A5A5A5A5A5A5;
  endfunction
  task conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One command cycle: write, advance, select, sleep, address, lanes, data
  task cmd(input logic w, ad, s, z, input logic [17:0] a, input logic [7:0] l,
           input logic [71:0] d);
    logic        tk;
    logic [71:0] m;
    begin
      @(posedge i_clk);
      tk = s && !z;
      wr_n <= !w; advance_load <= ad; a_n <= !s; b <= s; c_n <= !s; slp <= z;
      addr <= a; ln_n <= l; wd <= d; ce_n <= 1'b0;
      wt <= tk && w && !ad;
      rv <= tk && !w;
      re <= (tk && !w) ? mem[a] : 72'h0;
      // Reference store takes enabled lanes only
      if (tk && w && !ad) begin
        m = mem.exists(a) ? mem[a] : 72'h0;
        for (int k = 0; k < 8; k++) if (!l[k]) m[9*k+:9] = d[9*k+:9];
        mem[a] = m;
      end
    end
  endtask
  // One slow test clock period, rise then fall, each phase several clocks
  task tpulse(input logic m);
    @(posedge i_clk) begin tms <= m; tck <= 1'b1; end
    repeat (2) @(posedge i_clk);
    tck <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  // Gate the clock for n edges
  task stall(input int n);
    repeat (n) @(posedge i_clk) ce_n <= 1'b1;
  endtask
  // Expected read stream, shifted on counted edges only
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      error_cnt++;
      conclude;
    end
    if (i_reset) begin
      r1 <= 1'b0; r2 <= 1'b0;
    end else begin
      if (!ce_n) begin
        r1 <= rv; e1 <= re; r2 <= r1; e2 <= e1;
      end
      if (!oe_n && !slp) `CHK("data_oe", ft_n ? r2 : r1, doe)
      if (ft_n ? r2 : r1) `CHK("read_data", ft_n ? e2 : e1, dout)
    end
  end
  // Pass 0 pipelined and interleaved, pass 1 flow and linear
  initial begin
    for (int p = 0; p < 2; p++) begin
      i_reset <= 1'b1; ft_n <= (p == 0); lbo_n <= (p == 0);
      repeat (6) @(posedge i_clk);
      i_reset <= 1'b0;
      for (int k = 0; k < 4; k++) cmd(1, 0, 1, 0, 18'h8 + k, 8'h00, pat(k[8:0]));
      cmd(1, 0, 1, 0, 18'h9, 8'hFE, pat(9'h7));
      cmd(1, 0, 1, 0, 18'hA, 8'hFF, pat(9'h8));
      cmd(1, 0, 0, 0, 18'h8, 8'h00, pat(9'h9));
      cmd(0, 0, 1, 0, 18'h9, 8'hFF, 72'h0);
      for (int n = 1; n < 4; n++) // Burst beats in strap order
        cmd(0, 1, 1, 0, 18'h8 + 18'(lbo_n ? (1 ^ n) : ((1 + n) % 4)), 8'hFF, 72'h0);
      cmd(1, 0, 1, 0, 18'hB, 8'h00, pat(9'h5));
      cmd(0, 0, 1, 1, 18'h8, 8'hFF, 72'h0);
      cmd(0, 0, 1, 0, 18'h8, 8'hFF, 72'h0);
      stall(2);
      cmd(0, 0, 1, 0, 18'hB, 8'hFF, 72'h0);
      repeat (4) cmd(0, 0, 1, 0, 18'h9, 8'hFF, 72'h0);
      oe_n <= 1'b1;
      #20 `CHK("oe_off", 1'b0, doe)
      @(posedge i_clk) oe_n <= 1'b0;
      repeat (4) cmd(0, 0, 0, 0, 18'h0, 8'hFF, 72'h0);
    end
    // Walk to the data shift state and read the identity out, low bit first
    tpulse(1'b0); tpulse(1'b1); tpulse(1'b0); tpulse(1'b0);
    `CHK("tdo_oe", 1'b1, tdoe)
    for (int i = 0; i < 32; i++) begin
      idv[i] = tdo;
      tpulse(i == 31);
    end
    `CHK("idcode", `SBSP_ID_CODE, idv)
    conclude;
  end
endmodule // testbench
bind sbsp_port sbsp_port_sva u_sbsp_port_sva (.i_clk(i_clk), .i_reset(i_reset),
  .i_clk_enable_n(i_clk_enable_n), .i_write_n(i_write_n), .i_chip_select_a_n(i_chip_select_a_n),
  .i_chip_select_b(i_chip_select_b), .i_chip_select_c_n(i_chip_select_c_n),
  .i_advance_load(i_advance_load), .i_output_enable_n(i_output_enable_n),
  .i_sleep_request(i_sleep_request), .i_flow_through_select_n(i_flow_through_select_n),
  .o_data(o_data), .o_data_oe(o_data_oe), .o_tdo_oe(o_tdo_oe));
`default_nettype wire
